// ### rtl/sdce_regs.svh
// offsets, field codes, characters and timing figures of the command engine
`ifndef SDCE_REGS_SVH
`define SDCE_REGS_SVH
`define SDCE_CTRL_OFS 12'h000
`define SDCE_STAT_OFS 12'h004
`define SDCE_ADDR_RST 4'h1
`define SDCE_RESP_OK 2'h0
`define SDCE_RESP_ERR 2'h2
`define SDCE_CLK_KHZ 25000
`define SDCE_BUSY_MS 2500
`define SDCE_BUSY_CYC (`SDCE_BUSY_MS * `SDCE_CLK_KHZ)
`define SDCE_NSEQ 8'h28
`define SDCE_SEQ_BYTES 2560
`define SDCE_ST_EMPTY 2'h0
`define SDCE_ST_BAD 2'h1
`define SDCE_ST_OK 2'h2
`define SDCE_CH_CR 8'h0d
`define SDCE_CH_SP 8'h20
`define SDCE_CH_STAR 8'h2a
`define SDCE_CH_UNDER 8'h5f
`define SDCE_W_QUERY 24'h585353
`define SDCE_W_STEPSET 24'h585354
`define SDCE_W_TRACESET 24'h585452
`define SDCE_W_TERM 24'h005854
`define SDCE_W_UPLOAD 24'h005855
`define SDCE_W_XD 24'h005844
`define SDCE_W_XR 24'h005852
`define SDCE_W_STEP 24'h000023
`define SDCE_W_Y 24'h000059
`define SDCE_W_Z 24'h00005a
`define SDCE_W_K 24'h00004b
`define SDCE_W_L 24'h00004c
`define SDCE_W_N 24'h00004e
`endif

// ### rtl/sdce_pkg.sv
// types shared by the command engine and its register slave
package sdce_pkg;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01, S_PARSE = 7'h02, S_MSG = 7'h04, S_RUN = 7'h08,
		S_CMD = 7'h10, S_BUSY = 7'h20, S_SPARE = 7'h40
	} sdce_state_t;
	// one parsed token: address, letters, number
	typedef struct packed {
		logic addr;
		logic [3:0] av;
		logic [23:0] word;
		logic [7:0] num;
		logic seen;
		logic [1:0] nlet;
		logic bad;
	} sdce_tok_t;
	// status shown to software
	typedef struct packed {
		logic busy, running, defining, step, trace;
		logic [5:0] seq;
	} sdce_stat_t;
	typedef struct packed {
		sdce_state_t st;
		logic rx_ready, tx_valid;
		logic [7:0] tx_data;
		logic [63:0] lb, cb;
		logic [3:0] lb_len, cb_len;
		logic step, trace, running, defining, dovf, pend, in_loop, loop_exit;
		logic sa_m, sa, cmd_go, pos_clear, upl;
		logic [5:0] dseq, rseq, useq, olen;
		logic [6:0] dptr, rpos, loop_pos, oi;
		logic [7:0] credit, loop_tgt, iter;
		logic [47:0][7:0] ob;
		logic [63:0] cmd_text;
		logic [3:0] cmd_len;
		logic [25:0] busy;
	} sdce_core_t;
	typedef struct packed {
		logic awready, wready, arready, bvalid, rvalid, awv, wv, ws;
		logic [11:0] awa;
		logic [31:0] wd, rdata;
		logic [1:0] bresp, rresp;
		logic [3:0] unit_addr;
	} sdce_axi_t;
endpackage

// ### rtl/sdce_axil.sv
// axi4-lite register slave of the command engine
`timescale 1ns/1ps
`include "sdce_regs.svh"
module sdce_axil import sdce_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// engine side
	input sdce_stat_t stat,
	output logic [3:0] unit_addr
);
	sdce_axi_t s, n;

	////////////////////////////////////////////////////////////////
	// one write and one read at a time; address and data in either order
	always_comb begin
		n = s;
		if (bready && s.bvalid) n.bvalid = 1'b0;
		if (rready && s.rvalid) n.rvalid = 1'b0;
		if (awvalid && s.awready) begin
			n.awv = 1'b1;
			n.awa = awaddr;
		end
		if (wvalid && s.wready) begin
			n.wv = 1'b1;
			n.wd = wdata;
			n.ws = wstrb[0];
		end
		if (s.awv && s.wv && !s.bvalid) begin
			n.awv = 1'b0;
			n.wv = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `SDCE_RESP_OK;
			if (s.awa == `SDCE_CTRL_OFS) begin
				if (s.ws) n.unit_addr = s.wd[3:0];
			end else if (s.awa != `SDCE_STAT_OFS) begin
				n.bresp = `SDCE_RESP_ERR;
			end
		end
		if (arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = `SDCE_RESP_OK;
			if (araddr == `SDCE_CTRL_OFS) begin
				n.rdata = {28'h0, s.unit_addr};
			end else if (araddr == `SDCE_STAT_OFS) begin
				n.rdata = {18'h0, stat.seq, 3'h0, stat.trace, stat.step,
					stat.defining, stat.running, stat.busy};
			end else begin
				n.rdata = 32'h0;
				n.rresp = `SDCE_RESP_ERR;
			end
		end
		// readies drop while a response waits, so nothing is ever lost
		n.awready = !n.awv && !n.bvalid;
		n.wready = !n.wv && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.unit_addr <= `SDCE_ADDR_RST;
		end else begin
			s <= n;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign unit_addr = s.unit_addr;
endmodule

// ### rtl/sdce_core.sv
// sequence debug command engine: parser, store, runner, tracer, uploader
`timescale 1ns/1ps
`include "sdce_regs.svh"
////////////////////////////////////////////////////////////////
// Overview of operation
// - status query replies asterisk and code 0/1/2
// - step mode 0/1, default 0, replies message
// - step n runs exactly n commands, waits
// - stepping only under serial control
// - trace plus step reports each stepped command
// - kill aborts the running sequence
// - definition open until terminator closes it
// - trace mode 0/1, reports only while running
// - trace shows three-digit sequence and loop count
// - upload sends asterisk, text, extra return
// - upload turns delimiters into underscores
// - empty upload sends asterisk and underscore
// - stop-loop finishes pass, then leaves loop
// - exited loop stays left until re-entered
// - soft reset restores settings, clears counters
// - busy 2.5 s, commands discarded meanwhile
////////////////////////////////////////////////////////////////
module sdce_core import sdce_pkg::*; #(
	parameter int BUSY_CYC = `SDCE_BUSY_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// received characters, from the serial framer
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	// transmitted characters, to the serial framer
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// motion executor
	output logic cmd_go,
	output logic [63:0] cmd_text,
	output logic [3:0] cmd_len,
	input wire logic cmd_done,
	output logic pos_clear,
	// stand-alone strap pin, asynchronous
	input wire logic stand_alone,
	// axi4-lite write channels
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	sdce_core_t s, n;
	sdce_tok_t lt, ct;
	sdce_stat_t stat;
	logic [3:0] unit_addr;
	logic [7:0] mem [0:`SDCE_SEQ_BYTES-1];
	logic [6:0] slen [0:39];
	logic [1:0] sst [0:39];
	logic we, fin, step_eff, seq_ok;
	logic [11:0] wa;
	logic [6:0] fin_len, olast, ulen, rlen;
	logic [1:0] fin_st;
	logic [7:0] rch, uch, och;
	logic [5:0] idx;
	logic [383:0] tail;
	logic [5:0] tl;

	////////////////////////////////////////////////////////////////
	// token split: optional address digit, up to three letters, number
	function automatic sdce_tok_t parse(input logic [63:0] v, input logic [3:0] len);
		logic [63:0] b;
		logic [7:0] c;
		logic dig;
		parse = '0;
		b = v << {4'(4'h8 - len), 3'h0};
		for (int i = 0; i < 8; i++) begin
			c = b[63-8*i -: 8];
			dig = c >= 8'h30 && c <= 8'h39;
			if (4'(i) < len) begin
				if (i == 0 && dig) begin
					parse.addr = 1'b1;
					parse.av = c[3:0];
				end else if (dig) begin
					parse.num = 8'(parse.num * 8'h0a + c - 8'h30);
					parse.seen = 1'b1;
				end else begin
					if (parse.seen || parse.nlet == 2'h3) parse.bad = 1'b1;
					parse.word = {parse.word[15:0], c};
					parse.nlet = 2'(parse.nlet + 2'h1);
				end
			end
		end
	endfunction

	// right-aligned text of nb bytes moved to the head of the buffer
	function automatic logic [383:0] lal(input logic [383:0] v, input logic [5:0] nb);
		return v << {6'(6'h30 - nb), 3'h0};
	endfunction

	// three ascii digits
	function automatic logic [23:0] d3(input logic [7:0] x);
		return {8'(8'h30 + x / 8'h64), 8'(8'h30 + x / 8'h0a % 8'h0a), 8'(8'h30 + x % 8'h0a)};
	endfunction

	////////////////////////////////////////////////////////////////
	// stored sequences; text has no reset, lengths and codes do
	always_ff @(posedge aclk) begin
		if (we) mem[wa] <= rx_data;
	end

	generate
		for (genvar g = 0; g < 40; g++) begin : g_seq
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					slen[g] <= 7'h0;
					sst[g] <= `SDCE_ST_EMPTY;
				end else if (fin && s.dseq == 6'(g)) begin
					slen[g] <= fin_len;
					sst[g] <= fin_st;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// read ports and derived terms
	assign lt = parse(s.lb, s.lb_len);
	assign ct = parse(s.cb, s.cb_len);
	assign rch = mem[{s.rseq, s.rpos[5:0]}];
	assign rlen = slen[s.rseq];
	assign uch = mem[{s.useq, 6'(s.oi[5:0] - 6'h01)}];
	assign ulen = slen[s.useq];
	assign idx = 6'(lt.num - 8'h01);
	assign seq_ok = lt.num >= 8'h01 && lt.num <= `SDCE_NSEQ;
	assign step_eff = s.step && !s.sa;
	assign wa = {s.dseq, s.dptr[5:0]};
	// the terminator token and its delimiter were stored too; take them back
	assign fin_len = 7'(s.dptr - {3'h0, s.lb_len} - 7'h01);
	assign fin_st = s.dovf ? `SDCE_ST_BAD : `SDCE_ST_OK;
	assign tail = s.in_loop && ct.word != `SDCE_W_L ?
		384'({"_LOOP_COUNT_", d3(s.iter), `SDCE_CH_CR}) : 384'(`SDCE_CH_CR);
	assign tl = s.in_loop && ct.word != `SDCE_W_L ? 6'h10 : 6'h01;

	// next outgoing character; upload reads the store directly
	always_comb begin
		och = s.ob[6'(6'h2f - s.oi[5:0])];
		olast = 7'(s.olen - 6'h01);
		if (s.upl) begin
			olast = ulen == 7'h0 ? 7'h02 : 7'(ulen + 7'h02);
			if (s.oi == 7'h0) begin
				och = `SDCE_CH_STAR;
			end else if (s.oi <= ulen) begin
				och = uch == `SDCE_CH_SP || uch == `SDCE_CH_CR ? `SDCE_CH_UNDER : uch;
			end else if (ulen == 7'h0 && s.oi == 7'h01) begin
				och = `SDCE_CH_UNDER;
			end else begin
				och = `SDCE_CH_CR;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// main sequencer
	always_comb begin
		n = s;
		we = 1'b0;
		fin = 1'b0;
		n.sa_m = stand_alone;
		n.sa = s.sa_m;
		n.cmd_go = 1'b0;
		n.pos_clear = 1'b0;
		if (cmd_done) n.pend = 1'b0;
		if (tx_ready) n.tx_valid = 1'b0;
		unique case (s.st)
			S_IDLE: begin
				if (rx_valid && s.rx_ready) begin
					// while defining every character up to the 64th lands in the store
					if (s.defining) begin
						we = !s.dptr[6];
						if (s.dptr[6]) n.dovf = 1'b1;
						else n.dptr = 7'(s.dptr + 7'h01);
					end
					if (rx_data == `SDCE_CH_SP || rx_data == `SDCE_CH_CR) begin
						if (s.lb_len != 4'h0) n.st = S_PARSE;
					end else if (s.lb_len != 4'h8) begin
						n.lb = {s.lb[55:0], rx_data};
						n.lb_len = 4'(s.lb_len + 4'h1);
					end
				end else if (s.running && !s.pend && (!step_eff || s.credit != 8'h0)) begin
					n.st = S_RUN;
				end
			end
			S_PARSE: begin
				n.st = S_IDLE;
				n.lb_len = 4'h0;
				n.upl = 1'b0;
				n.oi = 7'h0;
				if (lt.bad || (lt.addr && lt.av != unit_addr)) begin
					n.st = S_IDLE;
				end else if (s.defining) begin
					if (lt.word == `SDCE_W_TERM) begin
						fin = 1'b1;
						n.defining = 1'b0;
					end
				end else begin
					case (lt.word)
						`SDCE_W_QUERY: if (seq_ok) begin
							n.ob = lal(384'({`SDCE_CH_STAR, 6'h0c, sst[idx], `SDCE_CH_CR}), 6'h03);
							n.olen = 6'h03;
							n.st = S_MSG;
						end
						`SDCE_W_STEPSET: if (lt.num < 8'h02) begin
							n.step = lt.num[0];
							n.ob = lt.num[0] ? lal(384'({"*STEP_MODE_ACTIVE", `SDCE_CH_CR}), 6'h12)
								: lal(384'({"*STEP_MODE_INACTIVE", `SDCE_CH_CR}), 6'h14);
							n.olen = lt.num[0] ? 6'h12 : 6'h14;
							n.st = S_MSG;
						end
						`SDCE_W_TRACESET: if (lt.num < 8'h02) begin
							n.trace = lt.num[0];
							n.ob = lt.num[0] ? lal(384'({"*TRACE_MODE_ACTIVE", `SDCE_CH_CR}), 6'h13)
								: lal(384'({"*TRACE_MODE_INACTIVE", `SDCE_CH_CR}), 6'h15);
							n.olen = lt.num[0] ? 6'h13 : 6'h15;
							n.st = S_MSG;
						end
						`SDCE_W_UPLOAD: if (seq_ok) begin
							n.upl = 1'b1;
							n.useq = idx;
							n.st = S_MSG;
						end
						`SDCE_W_XD: if (seq_ok) begin
							n.defining = 1'b1;
							n.dseq = idx;
							n.dptr = 7'h0;
							n.dovf = 1'b0;
						end
						`SDCE_W_XR: if (seq_ok && sst[idx] == `SDCE_ST_OK) begin
							n.running = 1'b1;
							n.rseq = idx;
							n.rpos = 7'h0;
							n.cb_len = 4'h0;
							n.in_loop = 1'b0;
							n.loop_exit = 1'b0;
							n.credit = 8'h0;
						end
						`SDCE_W_STEP: if (step_eff && s.running) begin
							n.credit = 8'(s.credit + (lt.seen ? lt.num : 8'h01));
						end
						`SDCE_W_Y: if (s.in_loop) n.loop_exit = 1'b1;
						`SDCE_W_K: begin
							n.running = 1'b0;
							n.credit = 8'h0;
							n.in_loop = 1'b0;
						end
						`SDCE_W_Z: begin
							// settings back to power-up, counters cleared
							n.step = 1'b0;
							n.trace = 1'b0;
							n.running = 1'b0;
							n.credit = 8'h0;
							n.in_loop = 1'b0;
							n.pos_clear = 1'b1;
							n.busy = 26'(BUSY_CYC - 1);
							n.st = S_BUSY;
						end
						default: n.st = S_IDLE;
					endcase
				end
			end
			S_RUN: begin
				// walk stored text one character a cycle
				if (s.rpos >= rlen) begin
					n.running = 1'b0;
					n.st = S_IDLE;
				end else begin
					n.rpos = 7'(s.rpos + 7'h01);
					if (rch == `SDCE_CH_SP || rch == `SDCE_CH_CR) begin
						if (s.cb_len != 4'h0) n.st = S_CMD;
					end else if (s.cb_len != 4'h8) begin
						n.cb = {s.cb[55:0], rch};
						n.cb_len = 4'(s.cb_len + 4'h1);
					end
				end
			end
			S_CMD: begin
				n.cb_len = 4'h0;
				n.st = S_IDLE;
				n.upl = 1'b0;
				n.oi = 7'h0;
				if (step_eff) n.credit = 8'(s.credit - 8'h01);
				if (ct.word == `SDCE_W_L) begin
					n.in_loop = 1'b1;
					n.loop_exit = 1'b0;
					n.loop_pos = s.rpos;
					n.loop_tgt = ct.num;
					n.iter = 8'h01;
				end else if (ct.word == `SDCE_W_N) begin
					// a zero count loops until a stop-loop arrives
					if (s.in_loop) begin
						if (s.loop_exit || (s.loop_tgt != 8'h0 && s.iter >= s.loop_tgt)) begin
							n.in_loop = 1'b0;
						end else begin
							n.iter = 8'(s.iter + 8'h01);
							n.rpos = s.loop_pos;
						end
					end
				end else begin
					n.cmd_go = 1'b1;
					n.cmd_text = s.cb;
					n.cmd_len = s.cb_len;
					n.pend = 1'b1;
				end
				if (s.trace) begin
					n.ob = lal(384'({"*SEQUENCE_", d3(8'(s.rseq) + 8'h01), "_COMMAND_"}), 6'h16)
						| (lal(384'(s.cb), {2'h0, s.cb_len}) >> 9'd176)
						| (lal(tail, tl) >> {6'(6'h16 + {2'h0, s.cb_len}), 3'h0});
					n.olen = 6'(6'h16 + {2'h0, s.cb_len} + tl);
					n.st = S_MSG;
				end
			end
			S_MSG: begin
				if (!s.tx_valid || tx_ready) begin
					n.tx_valid = 1'b1;
					n.tx_data = och;
					n.oi = 7'(s.oi + 7'h01);
					if (s.oi == olast) n.st = S_IDLE;
				end
			end
			S_BUSY: begin
				// characters are taken and dropped until the count runs out
				if (s.busy == 26'h0) n.st = S_IDLE;
				else n.busy = 26'(s.busy - 26'h1);
			end
			default: n.st = S_IDLE;
		endcase
		n.rx_ready = n.st == S_IDLE || n.st == S_BUSY;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.st <= S_IDLE;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////
	// register slave
	assign stat = '{busy: s.st == S_BUSY, running: s.running, defining: s.defining,
		step: s.step, trace: s.trace, seq: s.rseq};

	sdce_axil u_regs (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.stat(stat), .unit_addr(unit_addr)
	);

	assign rx_ready = s.rx_ready;
	assign tx_data = s.tx_data;
	assign tx_valid = s.tx_valid;
	assign cmd_go = s.cmd_go;
	assign cmd_text = s.cmd_text;
	assign cmd_len = s.cmd_len;
	assign pos_clear = s.pos_clear;
endmodule

// ### dv/sdce_chk_sva.sv
// port assertions of the command engine
`timescale 1ns/1ps
module sdce_chk #(
	parameter int BUSY_CYC = 20
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// serial side
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	// executor side
	input wire logic cmd_go,
	input wire logic [3:0] cmd_len,
	input wire logic pos_clear,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [31:0] quiet;
	////////////////////////////////////////////////////////////////
	// cycles left of the busy period; margin of two for the exit edge
	always_ff @(posedge aclk) begin
		if (!aresetn) quiet <= 32'h0;
		else if (pos_clear) quiet <= BUSY_CYC;
		else if (quiet != 32'h0) quiet <= quiet - 32'h1;
	end
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	////////////////////////////////////////////////////////////////
	a_go_pulse: assert property (cmd_go |=> !cmd_go)
		else $error("go pulse longer than one cycle");
	a_go_len: assert property (cmd_go |-> cmd_len inside {[4'h1:4'h8]})
		else $error("command length out of range");
	a_clear_pulse: assert property (pos_clear |=> !pos_clear)
		else $error("clear pulse longer than one cycle");
	a_busy_quiet: assert property (quiet > 32'h2 |-> !tx_valid && !cmd_go)
		else $error("activity during busy period");
	a_busy_listen: assert property (pos_clear |-> ##[1:2] rx_ready [*4])
		else $error("input not drained while busy");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx char dropped before taken");
	a_wr_answer: assert property (s_wr_taken |-> ##2 bvalid && !awready)
		else $error("write answer late");
	a_rd_answer: assert property (s_rd_taken |=> rvalid && !arready)
		else $error("read answer late");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	a_reset_idle: assert property (!$past(aresetn) |-> !tx_valid && !cmd_go && !bvalid)
		else $error("output active at reset release");
endmodule
bind sdce_core sdce_chk #(.BUSY_CYC(BUSY_CYC)) chk (.aclk, .aresetn, .rx_ready, .tx_data,
	.tx_valid, .tx_ready, .cmd_go, .cmd_len, .pos_clear, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready);

// ### dv/sdce_host.sv
// host model: sends text commands, collects replies
`timescale 1ns/1ps
module sdce_host (
	// clock
	input wire logic aclk,
	// characters to the engine
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// characters from the engine
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic slow = 1'b0;
	logic [7:0] q[$];
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// one char per handshake; slow mode stalls every other cycle
	always @(posedge aclk) begin
		if (tx_valid && tx_ready) q.push_back(tx_data);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	// caller ends every command with its delimiter
	task send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			rx_data <= s[i];
			rx_valid <= 1'b1;
			@(posedge aclk);
			while (!rx_ready) @(posedge aclk);
		end
		rx_valid <= 1'b0;
		rx_data <= ~rx_data; // released line must not keep the last char
		@(posedge aclk);
	endtask
	// collect until ncr returns have arrived
	task get(input int ncr, output string s);
		int n;
		n = 0;
		s = "";
		while (n < ncr) begin
			@(posedge aclk);
			while (q.size() != 0) begin
				if (q[0] == 8'h0d) n++;
				s = $sformatf("%s%c", s, q.pop_front());
			end
		end
	endtask
endmodule

// ### dv/tb_sequence_debug_command_engine.sv
// bench of the sequence debug command engine
`timescale 1ns/1ps
module tb_sequence_debug_command_engine;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] rx_data, tx_data;
	logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_go, pos_clear;
	logic cmd_done = 1'b0;
	logic stand_alone = 1'b0;
	logic [63:0] cmd_text;
	logic [3:0] cmd_len;
	logic [3:0] wstrb = 4'hf;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata, v;
	logic [1:0] bresp, rresp, r;
	int mismatches = 0, checked = 0, gos = 0, clears = 0, dly = 0;
	string s;
	always #20 aclk = ~aclk;
	sdce_core #(.BUSY_CYC(20)) dut (.aclk, .aresetn, .rx_data, .rx_valid, .rx_ready,
		.tx_data, .tx_valid, .tx_ready, .cmd_go, .cmd_text, .cmd_len, .cmd_done, .pos_clear,
		.stand_alone, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	sdce_host host (.aclk, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready);
	////////////////////////////////////////////////////////////////
	// executor stand-in: done four cycles after each go
	always @(posedge aclk) begin
		if (cmd_go) gos <= gos + 1;
		if (pos_clear) clears <= clears + 1;
		dly <= cmd_go ? 3 : (dly > 0 ? dly - 1 : 0);
		cmd_done <= (dly == 1);
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task chs(input string n, input string e, input string g);
		checked++;
		if (g != e) begin
			mismatches++;
			$display("Error %s expected %s seen %s", n, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// one command, one expected reply
	task cmd(input string c, input string e);
		host.send(c);
		host.get(1, s);
		chs(c, e, s);
	endtask
	task none(input string n);
		repeat (60) @(posedge aclk);
		chk(n, 32'h0, host.q.size());
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs();
		rd(12'h000);
		chk("ctrl reset", 32'h1, v);
		rd(12'h008);
		chk("unmapped read", 32'h80000000, {r, v[29:0]});
		wr(12'h008, 32'h5);
		chk("unmapped write", 32'h2, r);
		wr(12'h004, 32'hff);
		chk("status write", 32'h0, r);
	endtask
	task t_addr();
		host.send("2XSS1\r");
		none("foreign unit");
		wr(12'h000, 32'h2);
		cmd("2XSS1\r", "*0\r");
		wr(12'h000, 32'h1);
		cmd("XSS3\r", "*0\r");
	endtask
	task t_define();
		cmd("1XSS1\r", "*0\r");
		host.send("XD1 ");
		repeat (5) @(posedge aclk);
		rd(12'h004);
		chk("defining open", 32'h1, v[2]);
		host.send("A5 V2 G XT\r");
		repeat (5) @(posedge aclk);
		rd(12'h004);
		chk("defining closed", 32'h0, v[2]);
		cmd("XSS1\r", "*2\r");
		host.slow = 1'b1;
		host.send("XU1\r");
		host.get(2, s);
		host.slow = 1'b0;
		chs("upload head", "*", s.substr(0, 0));
		chs("upload tail", "\r\r", s.substr(s.len() - 2, s.len() - 1));
		chs("upload body", "A5_V2_G_", s.substr(1, s.len() - 3));
		cmd("XU2\r", "*_\r");
	endtask
	task t_step();
		cmd("XST1\r", "*STEP_MODE_ACTIVE\r");
		cmd("XTR1\r", "*TRACE_MODE_ACTIVE\r");
		host.send("XR1\r");
		none("no trace before step");
		chk("wait for step", 32'h0, gos);
		host.send("#2\r");
		host.get(2, s);
		chs("trace", "*SEQUENCE_001_COMMAND_A5\r*SEQUENCE_001_COMMAND_V2\r", s);
		repeat (40) @(posedge aclk);
		chk("step count", 32'h2, gos);
		chk("command text", 32'h00025632, {12'h0, cmd_len, cmd_text[15:0]});
		// stand-alone makes stepping void, so the run goes on freely
		stand_alone <= 1'b1;
		repeat (4) @(posedge aclk);
		host.send("#\r");
		host.get(1, s);
		chs("free run", "*SEQUENCE_001_COMMAND_G\r", s);
		repeat (40) @(posedge aclk);
		chk("stand-alone run", 32'h3, gos);
		stand_alone <= 1'b0;
		host.send("XR1\r");
		repeat (10) @(posedge aclk);
		rd(12'h004);
		chk("running", 32'h1, v[1]);
		host.send("K\r");
		repeat (10) @(posedge aclk);
		rd(12'h004);
		chk("killed", 32'h0, v[1]);
		cmd("XST0\r", "*STEP_MODE_INACTIVE\r");
		cmd("XTR0\r", "*TRACE_MODE_INACTIVE\r");
	endtask
	task t_loop();
		host.send("XD2 L2 G N XT\r");
		host.send("XD3 L G N V1 XT\r");
		cmd("XTR1\r", "*TRACE_MODE_ACTIVE\r");
		host.send("XR2\r");
		host.get(5, s);
		chs("loop trace", {
			"*SEQUENCE_002_COMMAND_L2\r",
			"*SEQUENCE_002_COMMAND_G_LOOP_COUNT_001\r",
			"*SEQUENCE_002_COMMAND_N_LOOP_COUNT_001\r",
			"*SEQUENCE_002_COMMAND_G_LOOP_COUNT_002\r",
			"*SEQUENCE_002_COMMAND_N_LOOP_COUNT_002\r"}, s);
		cmd("XTR0\r", "*TRACE_MODE_INACTIVE\r");
		// endless loop, left only by the stop-loop command
		host.send("XR3\r");
		repeat (60) @(posedge aclk);
		host.send("Y\r");
		repeat (60) @(posedge aclk);
		rd(12'h004);
		chk("loop left", 32'h0, v[1]);
		chk("after loop", 32'h00025631, {12'h0, cmd_len, cmd_text[15:0]});
	endtask
	task t_reset();
		cmd("XST1\r", "*STEP_MODE_ACTIVE\r");
		host.send("Z\r");
		rd(12'h004);
		chk("busy and step", 32'h1, v[3:0]);
		host.send("XSS1\r");
		none("busy discards");
		chk("clear pulse", 32'h1, clears);
		cmd("XSS1\r", "*2\r");
	endtask
	task end_of_test();
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_addr();
		t_define();
		t_step();
		t_loop();
		t_reset();
		end_of_test();
	end
	// whole run needs a little over a thousand cycles
	initial begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		end_of_test();
	end
endmodule
